// ---- lcb_engine.sv ----
// command block list walker and statistics counter updater
`timescale 1ns/100ps
`default_nettype none

module lcb_engine
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // system memory master
    output lcb_pkg::lcb_mem_req_s o_mem,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    // receive path
    input wire lcb_pkg::lcb_rx_evt_s i_rx,
    input wire logic i_ru_no_resources,
    // command unit done event
    output logic o_cmd_done_event
);
    import lcb_pkg::*;

    lcb_state_e state_ff;
    lcb_mem_req_s mem_ff;
    logic [1:0] mode_ff;
    logic monitor_ff;
    logic [31:0] mem_base_ff;
    logic [31:0] scb_base_ff;
    logic [1:0] cus_ff;
    logic cx_ff;
    logic [31:0] cur_cb_ff;
    logic [31:0] link_ff;
    logic [31:0] word0_ff;
    logic [31:0] rfa_ff;
    logic cu_start_ff;
    logic cu_resume_ff;
    logic ru_start_ff;
    logic [NUM_CNT-1:0] pend_ff;
    logic [2:0] cnt_idx_ff;
    logic ovr_prev_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    logic linear;
    logic apb_wr;
    logic apb_rd_setup;
    logic sel_cnt;
    logic sel_ru;
    logic sel_cu;
    logic sel_resume;
    logic sel_walk;
    logic [2:0] pick_idx;
    logic [NUM_CNT-1:0] grab;
    logic [NUM_CNT-1:0] new_evt;
    logic fe;
    logic cmd_ok;
    logic cx_set;
    logic [31:0] rd_word;

    assign linear = (mode_ff == MODE_LINEAR);
    assign apb_wr = i_psel & i_penable & i_pwrite & pready_ff;
    assign apb_rd_setup = i_psel & i_penable & ~pready_ff;

    // offsets resolve against the segment base outside linear mode
    function automatic logic [31:0] mem_addr(input logic lin,
                                             input logic [31:0] base,
                                             input logic [31:0] ptr);
        mem_addr = lin ? ptr : base + {16'h0000, ptr[15:0]};
    endfunction

    // pointer field as stored: full word in linear mode, low half else
    function automatic logic [31:0] ptr_field(input logic lin,
                                              input logic [31:0] w);
        ptr_field = lin ? w : {16'h0000, w[15:0]};
    endfunction

    // frames whose collision hit the preamble count nowhere
    assign fe = i_rx.frame_end
        & ~(i_rx.collision & i_rx.coll_in_preamble);

    // several counters may fire for one frame
    always_comb
    begin
        new_evt = '0;
        new_evt[CNT_CHECKSUM] = fe & i_rx.crc_err
            & ~i_rx.misaligned;
        new_evt[CNT_MISALIGN] = fe & i_rx.crc_err
            & i_rx.misaligned;
        new_evt[CNT_RUNT] = fe & (i_rx.runt
            | (i_rx.collision & i_rx.coll_before_64));
        new_evt[CNT_NO_RESOURCE] = fe & (monitor_ff
            | (i_rx.no_res_good & i_ru_no_resources));
        new_evt[CNT_OVERRUN] = fe & i_rx.overrun
            & ~ovr_prev_ff;
        new_evt[CNT_COLLISION] = fe & i_rx.collision
            & ~i_rx.coll_before_64;
    end

    // an outage stays flagged until a frame gets through
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            ovr_prev_ff <= 1'b0;
        else if (fe)
            ovr_prev_ff <= i_rx.overrun;
    end

    // lowest pending counter is served first
    always_comb
    begin
        pick_idx = 3'h0;
        for (int i = NUM_CNT - 1; i >= 0; i--)
        begin
            if (pend_ff[i])
                pick_idx = i[2:0];
        end
    end

    // counters outrank list walking; work starts only when idle
    always_comb
    begin
        sel_cnt = 1'b0;
        sel_ru = 1'b0;
        sel_cu = 1'b0;
        sel_resume = 1'b0;
        sel_walk = 1'b0;
        if (state_ff == ST_IDLE)
        begin
            if (|pend_ff)
                sel_cnt = 1'b1;
            else if (ru_start_ff)
                sel_ru = 1'b1;
            else if (cu_start_ff)
                sel_cu = 1'b1;
            else if (cu_resume_ff && cus_ff == CUS_SUSPENDED)
                sel_resume = 1'b1;
            else if (cus_ff == CUS_ACTIVE)
                sel_walk = 1'b1;
        end
        grab = '0;
        if (sel_cnt)
            grab[pick_idx] = 1'b1;
    end

    // a new event on a counter being grabbed keeps it pending
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            pend_ff <= '0;
        else
            pend_ff <= (pend_ff & ~grab) | new_evt;
    end

    // start and resume requests from software, set wins over taking
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cu_start_ff <= 1'b0;
            cu_resume_ff <= 1'b0;
            ru_start_ff <= 1'b0;
        end
        else
        begin
            cu_start_ff <= (cu_start_ff & ~sel_cu)
                | (apb_wr && i_paddr == REG_CTRL && i_pwdata[CTRL_CU_START]);
            cu_resume_ff <= (cu_resume_ff & ~sel_resume)
                | (apb_wr && i_paddr == REG_CTRL
                   && i_pwdata[CTRL_CU_RESUME]);
            ru_start_ff <= (ru_start_ff & ~sel_ru)
                | (apb_wr && i_paddr == REG_CTRL
                   && i_pwdata[CTRL_RU_START]);
        end
    end

    // reserved bits must be zero outside compatibility mode
    assign cmd_ok = (mode_ff == MODE_COMPAT)
        || ~|word0_ff[CB_RSV_MSB:CB_RSV_LSB];

    // memory sequencer and command unit
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_ff <= ST_IDLE;
            mem_ff <= '0;
            cus_ff <= CUS_IDLE;
            cur_cb_ff <= '0;
            link_ff <= '0;
            word0_ff <= '0;
            rfa_ff <= '0;
            cnt_idx_ff <= 3'h0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (sel_cnt)
                    begin
                        cnt_idx_ff <= pick_idx;
                        mem_ff.valid <= 1'b1;
                        mem_ff.write <= 1'b0;
                        mem_ff.lock <= 1'b1;
                        mem_ff.addr <= scb_base_ff
                            + (linear ? SCB_CNT_LIN : SCB_CNT_STD)
                            + {27'h0, pick_idx, 2'h0};
                        state_ff <= ST_CNT_RD;
                    end
                    else if (sel_ru)
                    begin
                        mem_ff.valid <= 1'b1;
                        mem_ff.write <= 1'b0;
                        mem_ff.addr <= scb_base_ff
                            + (linear ? SCB_RFA_LIN : SCB_PTR_STD);
                        state_ff <= ST_RFA_RD;
                    end
                    else if (sel_cu)
                    begin
                        mem_ff.valid <= 1'b1;
                        mem_ff.write <= 1'b0;
                        mem_ff.addr <= scb_base_ff
                            + (linear ? SCB_CBL_LIN : SCB_PTR_STD);
                        state_ff <= ST_CBL_RD;
                    end
                    else if (sel_resume)
                    begin
                        cur_cb_ff <= link_ff;
                        cus_ff <= CUS_ACTIVE;
                    end
                    else if (sel_walk)
                    begin
                        mem_ff.valid <= 1'b1;
                        mem_ff.write <= 1'b0;
                        mem_ff.addr <= mem_addr(linear, mem_base_ff,
                                                cur_cb_ff);
                        state_ff <= ST_CB_RD0;
                    end
                end
                ST_CNT_RD:
                begin
                    if (i_mem_ack)
                    begin
                        // bus stays locked into the write-back
                        mem_ff.write <= 1'b1;
                        mem_ff.wdata <= i_mem_rdata + CNT_STEP;
                        state_ff <= ST_CNT_WR;
                    end
                end
                ST_CNT_WR:
                begin
                    if (i_mem_ack)
                    begin
                        mem_ff.valid <= 1'b0;
                        mem_ff.write <= 1'b0;
                        mem_ff.lock <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_RFA_RD:
                begin
                    if (i_mem_ack)
                    begin
                        mem_ff.valid <= 1'b0;
                        rfa_ff <= linear ? i_mem_rdata
                            : {16'h0000, i_mem_rdata[31:16]};
                        state_ff <= ST_IDLE;
                    end
                end
                ST_CBL_RD:
                begin
                    if (i_mem_ack)
                    begin
                        mem_ff.valid <= 1'b0;
                        cur_cb_ff <= ptr_field(linear, i_mem_rdata);
                        cus_ff <= CUS_ACTIVE;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_CB_RD0:
                begin
                    if (i_mem_ack)
                    begin
                        word0_ff <= i_mem_rdata;
                        mem_ff.write <= 1'b1;
                        mem_ff.wdata <= {i_mem_rdata[31:16], 1'b0, 1'b1,
                                         i_mem_rdata[13:0]};
                        state_ff <= ST_CB_WRB;
                    end
                end
                ST_CB_WRB:
                begin
                    if (i_mem_ack)
                    begin
                        mem_ff.write <= 1'b0;
                        mem_ff.addr <= mem_ff.addr + CB_LINK_OFF;
                        state_ff <= ST_CB_RD1;
                    end
                end
                ST_CB_RD1:
                begin
                    if (i_mem_ack)
                    begin
                        // code zero and unknown codes do no extra work
                        link_ff <= ptr_field(linear, i_mem_rdata);
                        mem_ff.write <= 1'b1;
                        mem_ff.addr <= mem_ff.addr - CB_LINK_OFF;
                        mem_ff.wdata <= {word0_ff[31:16], 1'b1, 1'b0,
                                         cmd_ok, word0_ff[12:0]};
                        state_ff <= ST_CB_WRC;
                    end
                end
                ST_CB_WRC:
                begin
                    if (i_mem_ack)
                    begin
                        mem_ff.valid <= 1'b0;
                        mem_ff.write <= 1'b0;
                        cur_cb_ff <= link_ff;
                        if (word0_ff[CB_EL])
                            cus_ff <= CUS_IDLE;
                        else if (word0_ff[CB_S])
                            cus_ff <= CUS_SUSPENDED;
                        state_ff <= ST_IDLE;
                    end
                end
                default:
                begin
                    mem_ff <= '0;
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    assign cx_set = (state_ff == ST_CB_WRC) & i_mem_ack
        & word0_ff[CB_I];

    // command done event, set wins over software clear
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            cx_ff <= 1'b0;
        else if (cx_set)
            cx_ff <= 1'b1;
        else if (apb_wr && i_paddr == REG_STATUS && i_pwdata[STAT_CX])
            cx_ff <= 1'b0;
    end

    // software configuration
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mode_ff <= MODE_COMPAT;
            monitor_ff <= 1'b0;
            mem_base_ff <= '0;
            scb_base_ff <= '0;
        end
        else if (apb_wr)
        begin
            case (i_paddr)
                REG_CTRL:
                begin
                    mode_ff <= i_pwdata[CTRL_MODE_LSB +: 2];
                    monitor_ff <= i_pwdata[CTRL_MONITOR];
                end
                REG_MEM_BASE: mem_base_ff <= i_pwdata;
                REG_SCB_BASE: scb_base_ff <= i_pwdata;
                default: mem_base_ff <= mem_base_ff;
            endcase
        end
    end

    // read mux
    always_comb
    begin
        rd_word = '0;
        case (i_paddr)
            REG_CTRL:
            begin
                rd_word[CTRL_MODE_LSB +: 2] = mode_ff;
                rd_word[CTRL_MONITOR] = monitor_ff;
            end
            REG_MEM_BASE: rd_word = mem_base_ff;
            REG_SCB_BASE: rd_word = scb_base_ff;
            REG_STATUS:
            begin
                rd_word[STAT_CUS_LSB +: 2] = cus_ff;
                rd_word[STAT_CX] = cx_ff;
                rd_word[STAT_CNT_BUSY] = (|pend_ff) | mem_ff.lock;
            end
            REG_CUR_CB: rd_word = cur_cb_ff;
            REG_RFA: rd_word = rfa_ff;
            default: rd_word = '0;
        endcase
    end

    // apb answers with one wait state
    always_ff @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end
        else
        begin
            pready_ff <= apb_rd_setup;
            if (apb_rd_setup)
            begin
                prdata_ff <= i_pwrite ? '0 : rd_word;
                pslverr_ff <= ~(i_paddr == REG_CTRL
                    || i_paddr == REG_MEM_BASE || i_paddr == REG_SCB_BASE
                    || i_paddr == REG_STATUS || i_paddr == REG_CUR_CB
                    || i_paddr == REG_RFA);
            end
            else
                pslverr_ff <= 1'b0;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_mem = mem_ff;
    assign o_cmd_done_event = cx_ff;

endmodule // lcb_engine

`default_nettype wire

// ---- lcb_pkg.sv ----
// constants, types and register map of the lan command block engine
package lcb_pkg;

    // apb register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MEM_BASE = 8'h04;
    localparam logic [7:0] REG_SCB_BASE = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_CUR_CB = 8'h10;
    localparam logic [7:0] REG_RFA = 8'h14;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MONITOR = 2;
    localparam int CTRL_CU_START = 8;
    localparam int CTRL_CU_RESUME = 9;
    localparam int CTRL_RU_START = 10;

    // status register fields
    localparam int STAT_CUS_LSB = 0;
    localparam int STAT_CX = 4;
    localparam int STAT_CNT_BUSY = 5;

    // addressing modes
    localparam logic [1:0] MODE_COMPAT = 2'h0;
    localparam logic [1:0] MODE_SEGMENTED = 2'h1;
    localparam logic [1:0] MODE_LINEAR = 2'h2;

    // command unit status codes
    localparam logic [1:0] CUS_IDLE = 2'h0;
    localparam logic [1:0] CUS_SUSPENDED = 2'h1;
    localparam logic [1:0] CUS_ACTIVE = 2'h2;

    // control block offsets from its base
    localparam logic [31:0] SCB_PTR_STD = 32'h0000_0004;
    localparam logic [31:0] SCB_CBL_LIN = 32'h0000_0008;
    localparam logic [31:0] SCB_RFA_LIN = 32'h0000_000C;
    localparam logic [31:0] SCB_CNT_STD = 32'h0000_0008;
    localparam logic [31:0] SCB_CNT_LIN = 32'h0000_0010;
    localparam logic [31:0] CB_LINK_OFF = 32'h0000_0004;

    // command block word 0 fields
    localparam int CB_EL = 31;
    localparam int CB_S = 30;
    localparam int CB_I = 29;
    localparam int CB_RSV_MSB = 28;
    localparam int CB_RSV_LSB = 19;
    localparam int CB_C = 15;
    localparam int CB_B = 14;
    localparam int CB_OK = 13;

    // statistics counters
    localparam int NUM_CNT = 6;
    localparam int CNT_CHECKSUM = 0;
    localparam int CNT_MISALIGN = 1;
    localparam int CNT_RUNT = 2;
    localparam int CNT_NO_RESOURCE = 3;
    localparam int CNT_OVERRUN = 4;
    localparam int CNT_COLLISION = 5;
    localparam logic [31:0] CNT_STEP = 32'h0000_0001;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_CNT_RD = 10'h002,
        ST_CNT_WR = 10'h004,
        ST_RFA_RD = 10'h008,
        ST_CBL_RD = 10'h010,
        ST_CB_RD0 = 10'h020,
        ST_CB_WRB = 10'h040,
        ST_CB_RD1 = 10'h080,
        ST_CB_WRC = 10'h100,
        ST_SPARE = 10'h200
    } lcb_state_e;

    // system memory request
    typedef struct packed {
        logic valid;
        logic write;
        logic lock;
        logic [31:0] addr;
        logic [31:0] wdata;
    } lcb_mem_req_s;

    // per frame report from the receive path
    typedef struct packed {
        logic frame_end;
        logic crc_err;
        logic misaligned;
        logic runt;
        logic no_res_good;
        logic overrun;
        logic collision;
        logic coll_before_64;
        logic coll_in_preamble;
    } lcb_rx_evt_s;

endpackage

// ---- lcb_mem_model.sv ----
// shared system memory as the host leaves it for the engine
`timescale 1ns/100ps
`default_nettype none
module lcb_mem_model
import lcb_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // engine request and answer
    input wire lcb_mem_req_s i_mem,
    input wire logic [3:0] i_delay,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    // host zeroes every word, counters included, before start
    logic [31:0] mem [0:255] = '{default: 32'h0000_0000};
    logic [3:0] wait_ff;

    // answers after i_delay idle cycles; released data toggles
    always @(posedge i_core_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_ack <= 1'b0;
            wait_ff <= 4'h0;
            o_rdata <= 32'h5555_5555;
        end
        else if (o_ack)
        begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
        end
        else if (i_mem.valid && wait_ff != i_delay)
            wait_ff <= wait_ff + 4'h1;
        else if (i_mem.valid)
        begin
            wait_ff <= 4'h0;
            o_ack <= 1'b1;
            if (i_mem.write)
                mem[i_mem.addr[9:2]] <= i_mem.wdata;
            else
                o_rdata <= mem[i_mem.addr[9:2]];
        end
    end
endmodule // lcb_mem_model
`default_nettype wire

// ---- lcb_engine_checker.sv ----
// port assertions for the command block engine
`timescale 1ns/100ps
`default_nettype none
module lcb_engine_checker
import lcb_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // memory and event
    input wire lcb_mem_req_s o_mem,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    input wire logic o_cmd_done_event
);
    default clocking dclk @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);

    wire logic rd_ack = o_mem.valid && o_mem.lock && !o_mem.write
        && i_mem_ack;
    wire logic wr_ack = o_mem.valid && o_mem.lock && o_mem.write
        && i_mem_ack;
    wire logic clr = i_psel && i_penable && i_pwrite && o_pready
        && i_paddr == REG_STATUS && i_pwdata[STAT_CX];

    property p_ready_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready longer than one cycle");
    property p_err_ready;
        o_pslverr |-> o_pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("pslverr without pready");
    property p_req_hold;
        o_mem.valid && !i_mem_ack |=> o_mem.valid && $stable(o_mem);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("memory request changed before ack");
    property p_lock_rd_wr;
        rd_ack |=> o_mem.valid && o_mem.lock && o_mem.write
            && o_mem.addr == $past(o_mem.addr);
    endproperty
    a_lock_rd_wr: assert property (p_lock_rd_wr)
        else $error("locked read not followed by locked write");
    property p_inc;
        rd_ack |=> o_mem.wdata == $past(i_mem_rdata) + CNT_STEP;
    endproperty
    a_inc: assert property (p_inc)
        else $error("counter write is not read value plus one");
    property p_lock_drop;
        wr_ack |=> !o_mem.lock;
    endproperty
    a_lock_drop: assert property (p_lock_drop)
        else $error("lock held after counter write");
    property p_cb_onehot;
        o_mem.valid && o_mem.write && !o_mem.lock
            |-> o_mem.wdata[CB_C] != o_mem.wdata[CB_B];
    endproperty
    a_cb_onehot: assert property (p_cb_onehot)
        else $error("block status write with both or neither flag");
    property p_done_stick;
        o_cmd_done_event && !clr |=> o_cmd_done_event;
    endproperty
    a_done_stick: assert property (p_done_stick)
        else $error("done event dropped without clear");

    c_cnt: cover property (wr_ack);
    c_done: cover property ($rose(o_cmd_done_event));
    c_err: cover property (o_pslverr);
endmodule // lcb_engine_checker

bind lcb_engine lcb_engine_checker i_lcb_engine_checker (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_mem(o_mem),
    .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata),
    .o_cmd_done_event(o_cmd_done_event)
);
`default_nettype wire

// ---- lcb_engine_tb.sv ----
// self-checking bench for the command block engine
`timescale 1ns/100ps
`default_nettype none
module lcb_engine_tb;
import lcb_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    lcb_mem_req_s mem_req;
    logic mem_ack;
    logic [31:0] mem_rdata;
    lcb_rx_evt_s rx = '0;
    logic no_res = 1'b0;
    logic done_evt;
    logic [3:0] delay = 4'h0;
    logic [31:0] rd;
    logic err;
    logic [31:0] exp_cnt [0:5] = '{default: 32'h0000_0000};
    int n_mismatch = 0;
    int samples_checked = 0;

    lcb_engine i_lcb_engine (
        .i_core_clk(core_clk), .i_resetn(resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_mem(mem_req), .i_mem_ack(mem_ack),
        .i_mem_rdata(mem_rdata), .i_rx(rx), .i_ru_no_resources(no_res),
        .o_cmd_done_event(done_evt));
    lcb_mem_model i_lcb_mem_model (
        .i_core_clk(core_clk), .i_resetn(resetn), .i_mem(mem_req),
        .i_delay(delay), .o_ack(mem_ack), .o_rdata(mem_rdata));

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // with act set, first waits until the command unit is running
    task automatic poll(input logic [1:0] cus, input logic act);
        if (act)
            do
                apb(1'b0, REG_STATUS, 32'h0000_0000);
            while (rd[STAT_CUS_LSB +: 2] !== CUS_ACTIVE);
        do
            apb(1'b0, REG_STATUS, 32'h0000_0000);
        while (rd[STAT_CNT_BUSY] !== 1'b0 || rd[1:0] !== cus);
    endtask

    // sends one frame report, then compares all six counters
    task automatic fr(input logic [8:0] e, input int a, input int b);
        @(posedge core_clk);
        rx <= e;
        @(posedge core_clk);
        rx <= '0;
        poll(CUS_IDLE, 1'b0);
        if (a < NUM_CNT)
            exp_cnt[a] += CNT_STEP;
        if (b < NUM_CNT)
            exp_cnt[b] += CNT_STEP;
        for (int k = 0; k < NUM_CNT; k++)
            chk(i_lcb_mem_model.mem[34 + k], exp_cnt[k]);
    endtask

    task automatic t_regs();
        apb(1'b1, REG_MEM_BASE, 32'h0000_0000);
        apb(1'b1, REG_SCB_BASE, 32'h0000_0080);
        apb(1'b0, REG_SCB_BASE, 32'h0000_0000);
        chk(rd, 32'h0000_0080);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
    endtask

    task automatic t_cnt();
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        i_lcb_mem_model.mem[34] = 32'hFFFF_FFFF;
        exp_cnt[0] = 32'hFFFF_FFFF;
        fr(9'h1A0, CNT_CHECKSUM, CNT_RUNT);
        delay <= 4'h3;
        fr(9'h1C0, CNT_MISALIGN, 9);
        fr(9'h110, 9, 9);
        no_res <= 1'b1;
        fr(9'h110, CNT_NO_RESOURCE, 9);
        no_res <= 1'b0;
        fr(9'h108, CNT_OVERRUN, 9);
        fr(9'h108, 9, 9);
        fr(9'h100, 9, 9);
        fr(9'h108, CNT_OVERRUN, 9);
        fr(9'h104, CNT_COLLISION, 9);
        fr(9'h106, CNT_RUNT, 9);
        fr(9'h105, 9, 9);
        apb(1'b1, REG_CTRL, 32'h0000_0004);
        fr(9'h100, CNT_NO_RESOURCE, 9);
    endtask

    // blocks sit on word addresses with completion clear
    task automatic t_cbl();
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        i_lcb_mem_model.mem[34] = 32'h0000_0100;
        i_lcb_mem_model.mem[64] = 32'h2000_0000;
        i_lcb_mem_model.mem[65] = 32'h0000_0200;
        i_lcb_mem_model.mem[128] = 32'h8008_0000;
        apb(1'b1, REG_CTRL, 32'h0000_0102);
        poll(CUS_IDLE, 1'b1);
        chk(i_lcb_mem_model.mem[64], 32'h2000_A000);
        chk(i_lcb_mem_model.mem[128], 32'h8008_8000);
        chk({31'h0, done_evt}, 32'h0000_0001);
        apb(1'b1, REG_STATUS, 32'h0000_0010);
        @(posedge core_clk);
        chk({31'h0, done_evt}, 32'h0000_0000);
        i_lcb_mem_model.mem[34] = 32'h0000_0300;
        i_lcb_mem_model.mem[192] = 32'h4000_0000;
        i_lcb_mem_model.mem[193] = 32'h0000_0340;
        i_lcb_mem_model.mem[208] = 32'h8000_0000;
        apb(1'b1, REG_CTRL, 32'h0000_0102);
        poll(CUS_SUSPENDED, 1'b1);
        chk(i_lcb_mem_model.mem[192], 32'h4000_A000);
        chk(i_lcb_mem_model.mem[208], 32'h8000_0000);
        chk({31'h0, done_evt}, 32'h0000_0000);
        apb(1'b1, REG_CTRL, 32'h0000_0202);
        poll(CUS_IDLE, 1'b1);
        chk(i_lcb_mem_model.mem[208], 32'h8000_A000);
        i_lcb_mem_model.mem[35] = 32'h1234_5678;
        apb(1'b1, REG_CTRL, 32'h0000_0402);
        // the fetch has landed once the pointer reads back
        do
            apb(1'b0, REG_RFA, 32'h0000_0000);
        while (rd !== 32'h1234_5678);
        i_lcb_mem_model.mem[35] = 32'h0000_0000;
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        apb(1'b0, REG_RFA, 32'h0000_0000);
        chk(rd, 32'h1234_5678);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs();
        t_cnt();
        t_cbl();
        report_and_stop();
    end

    initial
    begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // lcb_engine_tb
`default_nettype wire
